// ### fdcs_clock_system.sv
// Clock system: frequency-locked loop, source selects, fault flags, gating
`timescale 1ns/10ps
// Behaviour
// - Compare oscillator over two reference periods
// - Two capture periods then one adjust period
// - Loop off in generator-off sleep, or light sleep with neither aux nor sub-main from oscillator
// - Enabled loop tracks target via tap and modulation
// - Modulation rolls over at tap boundary
// - Source select switches clock, sets no fault
// - Fault flag with enable requests non-maskable interrupt
// - Idle async serial releases clock in deep sleep
// - Clearing bypass ends crystal-one digital bypass
// - Deepest sleep low-current unless bypass active
module fdcs_clock_system (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic oscClk,                 // Tunable oscillator, sampled
  input wire logic refClk,                 // Loop reference, sampled
  input wire logic loopEnable,             // Software loop enable
  input wire logic [15:0] targetCount,     // Wanted oscillator edges/window
  input wire fdcs_pkg::fdcs_mode_e powerMode,
  input wire logic clockGenOff,            // Clock-generator-off bit
  input wire logic intEntry,               // Interrupt entry pulse
  input wire fdcs_pkg::fdcs_select_s selIn, // Source selects, software
  input wire logic selWrite,               // Write strobe for selIn
  input wire logic cryOneFault,            // Crystal one fault detect
  input wire logic cryTwoFault,            // Crystal two fault detect
  input wire logic oscFault,               // Tunable oscillator fault
  input wire logic [2:0] faultClear,       // Clear xt1, xt2, osc flags
  input wire logic faultIntEnable,         // Fault interrupt enable
  input wire logic cryOneBypassIn,         // Crystal one bypass control
  input wire logic cryTwoBypassIn,         // Crystal two bypass control
  input wire fdcs_pkg::fdcs_serial_s serial,
  output logic [4:0] oscTapSelect,
  output logic [4:0] modulationCount,
  output fdcs_pkg::fdcs_select_s selOut,
  output logic [2:0] faultFlags,           // {osc, crystal two, one}
  output logic oscFaultFlag,
  output logic nmiRequest,
  output logic loopActive,
  output logic cryOneBypassActive,
  output logic lowCurrentMode,
  output logic serialClockRequest
);
  logic rstMeta, rstSync;                  // Released reset copy
  // Two-stage reset release, constant under asynchronous reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Edge detection of sampled reference and oscillator
  logic refDly_q, oscDly_q;
  logic refRise, oscRise;
  assign refRise = refClk & ~refDly_q;
  assign oscRise = oscClk & ~oscDly_q;

  // Loop gating state
  logic sleepGate_q, sleepGate_d;
  logic loopOn;
  logic auxOrSubFromOsc;
  fdcs_pkg::fdcs_phase_e phase_q, phase_d;
  logic [1:0] refCnt_q, refCnt_d;
  logic [15:0] oscCnt_q, oscCnt_d;
  logic [15:0] capture_q, capture_d;
  logic [4:0] tap_q, tap_d;
  logic [4:0] mod_q, mod_d;

  assign auxOrSubFromOsc = (selOut.auxSel == fdcs_pkg::SRC_OSC) ||
                           (selOut.subMainSel == fdcs_pkg::SRC_OSC);

  // Sleep gating: set in any cycle a gating mode holds, cleared by interrupt
  // entry or return to active so a short ISR reopens the loop.
  always_comb begin
    sleepGate_d = sleepGate_q;
    if (intEntry || powerMode == fdcs_pkg::FDCS_ACTIVE) begin
      sleepGate_d = 1'b0;
    end else if ((powerMode == fdcs_pkg::FDCS_SLEEP0 && !auxOrSubFromOsc) ||
                 (powerMode >= fdcs_pkg::FDCS_SLEEP1 && clockGenOff)) begin
      sleepGate_d = 1'b1;
    end
  end

  assign loopOn = loopEnable & ~sleepGate_q;

  // Loop sequencer: counts oscillator edges between reference edges.
  // Abandoning a partial correction on disable avoids drift from a
  // half-measured window.
  always_comb begin
    phase_d = phase_q;
    refCnt_d = refCnt_q;
    oscCnt_d = oscCnt_q;
    capture_d = capture_q;
    tap_d = tap_q;
    mod_d = mod_q;
    if (!loopOn) begin
      phase_d = fdcs_pkg::FDCS_IDLE;
      refCnt_d = 2'h0;
      oscCnt_d = fdcs_pkg::CNT_ZERO;
    end else begin
      unique case (phase_q)
        fdcs_pkg::FDCS_IDLE: begin
          // First reference edge opens the capture window
          if (refRise) begin
            phase_d = fdcs_pkg::FDCS_CAPTURE;
            refCnt_d = 2'h0;
            oscCnt_d = fdcs_pkg::CNT_ZERO;
          end
        end
        fdcs_pkg::FDCS_CAPTURE: begin
          if (oscRise) begin
            oscCnt_d = oscCnt_q + 16'h0001;
          end
          if (refRise) begin
            if (refCnt_q == 2'(fdcs_pkg::CAPTURE_PERIODS - 1)) begin
              phase_d = fdcs_pkg::FDCS_ADJUST;
              capture_d = oscCnt_q;
              refCnt_d = 2'h0;
            end else begin
              refCnt_d = refCnt_q + 2'h1;
            end
          end
        end
        fdcs_pkg::FDCS_ADJUST: begin
          // One reference period to apply the correction
          if (refRise) begin
            phase_d = fdcs_pkg::FDCS_CAPTURE;
            oscCnt_d = fdcs_pkg::CNT_ZERO;
            if (capture_q < targetCount) begin
              // Too slow: step modulation up, roll into next tap
              if (mod_q == fdcs_pkg::MOD_MAX) begin
                if (tap_q != fdcs_pkg::TAP_MAX) begin
                  tap_d = tap_q + 5'h01;
                  mod_d = 5'h00;
                end
              end else begin
                mod_d = mod_q + 5'h01;
              end
            end else if (capture_q > targetCount) begin
              // Too fast: step modulation down, borrow from tap
              if (mod_q == 5'h00) begin
                if (tap_q != 5'h00) begin
                  tap_d = tap_q - 5'h01;
                  mod_d = fdcs_pkg::MOD_MAX;
                end
              end else begin
                mod_d = mod_q - 5'h01;
              end
            end
          end
        end
        default: phase_d = fdcs_pkg::FDCS_IDLE;
      endcase
    end
  end

  // Source selects and fault flags
  fdcs_pkg::fdcs_select_s sel_q, sel_d;
  logic [2:0] flags_q, flags_d;
  always_comb begin
    sel_d = sel_q;
    if (selWrite) begin
      sel_d = selIn;
    end
    // Set wins over clear; a select write itself raises nothing
    flags_d = (flags_q & ~faultClear) |
              {oscFault, cryTwoFault, cryOneFault};
  end

  // Bypass and power-mode state
  logic cryOneByp_q, cryOneByp_d, lowCur_q, lowCur_d, serReq_q, serReq_d;
  always_comb begin
    cryOneByp_d = cryOneBypassIn;
    lowCur_d = (powerMode == fdcs_pkg::FDCS_SLEEP4) &&
               !cryOneByp_q && !cryTwoBypassIn;
    serReq_d = 1'b1;
    if (powerMode >= fdcs_pkg::FDCS_SLEEP3 && serial.asyncMode &&
        !serial.softReset && !serial.txBusy && !serial.rxBusy) begin
      serReq_d = 1'b0;
    end
  end

  // Edge history; reset level equals the idle pin level, so no false edge
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      refDly_q <= 1'b0;
      oscDly_q <= 1'b0;
    end else begin
      refDly_q <= refClk;
      oscDly_q <= oscClk;
    end
  end

  // Loop gate and sequencer registers
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      sleepGate_q <= 1'b0;
      phase_q <= fdcs_pkg::FDCS_IDLE;
      refCnt_q <= 2'h0;
      oscCnt_q <= fdcs_pkg::CNT_ZERO;
      capture_q <= fdcs_pkg::CNT_ZERO;
      tap_q <= fdcs_pkg::TAP_RESET;
      mod_q <= fdcs_pkg::MOD_RESET;
    end else begin
      sleepGate_q <= sleepGate_d;
      phase_q <= phase_d;
      refCnt_q <= refCnt_d;
      oscCnt_q <= oscCnt_d;
      capture_q <= capture_d;
      tap_q <= tap_d;
      mod_q <= mod_d;
    end
  end

  // Select and fault flag registers
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      sel_q <= '0;
      flags_q <= 3'h0;
    end else begin
      sel_q <= sel_d;
      flags_q <= flags_d;
    end
  end

  // Bypass and power-mode registers
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      cryOneByp_q <= 1'b0;
      lowCur_q <= 1'b0;
      serReq_q <= 1'b1;
    end else begin
      cryOneByp_q <= cryOneByp_d;
      lowCur_q <= lowCur_d;
      serReq_q <= serReq_d;
    end
  end

  // Outputs
  assign oscTapSelect = tap_q;
  assign modulationCount = mod_q;
  assign selOut = sel_q;
  assign faultFlags = flags_q;
  assign oscFaultFlag = |flags_q;
  assign nmiRequest = oscFaultFlag & faultIntEnable;
  assign loopActive = loopOn;
  assign cryOneBypassActive = cryOneByp_q;
  assign lowCurrentMode = lowCur_q;
  assign serialClockRequest = serReq_q;
endmodule : fdcs_clock_system

// ### fdcs_clock_system_properties.sv
// Port-level checks for the clock system
`timescale 1ns/10ps
module fdcs_clock_system_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic refClk,
  input wire fdcs_pkg::fdcs_mode_e powerMode,
  input wire logic clockGenOff,
  input wire logic intEntry,
  input wire fdcs_pkg::fdcs_select_s selIn,
  input wire logic selWrite,
  input wire logic [2:0] faultClear,
  input wire logic faultIntEnable,
  input wire logic cryOneBypassIn,
  input wire logic cryTwoBypassIn,
  input wire fdcs_pkg::fdcs_serial_s serial,
  input wire logic [4:0] oscTapSelect,
  input wire logic [4:0] modulationCount,
  input wire fdcs_pkg::fdcs_select_s selOut,
  input wire logic [2:0] faultFlags,
  input wire logic nmiRequest,
  input wire logic loopActive,
  input wire logic cryOneBypassActive,
  input wire logic lowCurrentMode,
  input wire logic serialClockRequest
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic refSeen_q; // Last sampled reference level
  logic [2:0] rise_q; // Reference rises since loop came on
  logic [2:0] rise_d;
  // Sleep with generator off, no interrupt pending
  wire slp = powerMode >= fdcs_pkg::FDCS_SLEEP1 && clockGenOff && !intEntry;
  // Async serial unit out of reset with no traffic
  wire idle = serial == 4'h8;
  // Saturate so a long run never wraps back below three
  always_comb rise_d = !loopActive ? 3'h0 :
    rise_q + {2'h0, refClk && !refSeen_q && rise_q != 3'h7};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      refSeen_q <= 1'b0;
      rise_q <= 3'h0;
    end else begin
      refSeen_q <= refClk;
      rise_q <= rise_d;
    end
  end
  chk_gap_change: assert property (
    $changed({oscTapSelect, modulationCount}) |-> rise_q >= 3'h3)
    else $error("correction before three reference periods");
  chk_idle_hold: assert property (
    !loopActive |=> $stable({oscTapSelect, modulationCount}))
    else $error("tap moved while loop off");
  chk_sleep_gate: assert property (slp [*2] |-> !loopActive)
    else $error("loop runs in gated sleep");
  chk_roll_up: assert property (
    oscTapSelect == $past(oscTapSelect) + 5'h01 |->
    modulationCount == 5'h00 && $past(modulationCount) == 5'h1F)
    else $error("tap step without modulation rollover");
  chk_sel_load: assert property (selWrite |=> selOut == $past(selIn))
    else $error("select not taken");
  chk_flag_hold: assert property (
    faultFlags[0] && !faultClear[0] |=> faultFlags[0])
    else $error("fault flag dropped uncleared");
  chk_nmi_req: assert property (
    nmiRequest == (|faultFlags && faultIntEnable))
    else $error("fault interrupt request wrong");
  chk_bypass_end: assert property (
    !cryOneBypassIn |=> !cryOneBypassActive)
    else $error("bypass still active");
  chk_low_current: assert property (
    powerMode == fdcs_pkg::FDCS_SLEEP4 && !cryOneBypassActive &&
    !cryTwoBypassIn |=> lowCurrentMode)
    else $error("low-current switch missing");
  chk_serial_rel: assert property (
    powerMode >= fdcs_pkg::FDCS_SLEEP3 && idle |=> !serialClockRequest)
    else $error("serial clock request held");
endmodule : fdcs_clock_system_properties

// ### fdcs_clock_system_test.sv
// Self-checking bench for the clock system
`timescale 1ns/10ps
module fdcs_clock_system_test;
  logic mclk = 1'b0, rst_n = 1'b0, oscClk = 1'b0, refClk = 1'b0;
  logic loopEnable = 1'b0, clockGenOff = 1'b0, intEntry = 1'b0;
  logic [15:0] targetCount = 16'h0000;
  fdcs_pkg::fdcs_mode_e powerMode = fdcs_pkg::FDCS_ACTIVE;
  fdcs_pkg::fdcs_select_s selIn = '0, selOut;
  fdcs_pkg::fdcs_serial_s serial = '0;
  logic selWrite = 1'b0, faultIntEnable = 1'b0;
  logic cryOneBypassIn = 1'b0, cryTwoBypassIn = 1'b0;
  logic [2:0] fault = 3'h0, faultClear = 3'h0, faultFlags; // {osc,two,one}
  logic [4:0] oscTapSelect, modulationCount;
  logic oscFaultFlag, nmiRequest, loopActive, cryOneBypassActive;
  logic lowCurrentMode, serialClockRequest;
  logic [9:0] hold; // Tap and modulation snapshot
  int failures = 0, checked = 0, cyc = 0;
  always #10 mclk = ~mclk;
  // Oscillator rises every 2 cycles, reference every 16; the ceiling
  // covers the long relock wait with margin
  always @(negedge mclk) begin
    cyc <= cyc + 1;
    oscClk <= ~oscClk;
    refClk <= cyc[3];
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end
  fdcs_clock_system u_fdcs_clock_system (.mclk, .rst_n, .oscClk, .refClk,
    .loopEnable, .targetCount, .powerMode, .clockGenOff, .intEntry, .selIn,
    .selWrite, .cryOneFault(fault[0]), .cryTwoFault(fault[1]),
    .oscFault(fault[2]), .faultClear, .faultIntEnable, .cryOneBypassIn,
    .cryTwoBypassIn, .serial, .oscTapSelect, .modulationCount, .selOut,
    .faultFlags, .oscFaultFlag, .nmiRequest, .loopActive,
    .cryOneBypassActive, .lowCurrentMode, .serialClockRequest);
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // One-cycle select write strobe
  task automatic write_sel(input fdcs_pkg::fdcs_select_s s);
    selIn = s;
    selWrite = 1'b1;
    tick(1);
    selWrite = 1'b0;
    tick(1);
  endtask : write_sel
  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    tick(10);
    rst_n = 1'b1;
    tick(3);
    check({oscTapSelect, modulationCount}, 16'h01E0);
    check({selOut, faultFlags, lowCurrentMode, serialClockRequest},
      16'h0001);
    for (int c = 0; c < 3; c++) begin
      write_sel({3{c[2:0]}});
      check({selOut, faultFlags}, {3{c[2:0]}} << 3);
    end
    // Select changes done with the fault interrupt off; clear flags once
    faultClear = 3'h7;
    tick(1);
    faultClear = 3'h0;
    tick(1);
    for (int i = 0; i < 3; i++) begin
      fault[i] = 1'b1;
      tick(1);
      fault = 3'h0;
      tick(3);
      check({faultFlags, nmiRequest}, 4'h2 << i);
      check(oscFaultFlag, 1'b1);
      faultIntEnable = 1'b1;
      tick(1);
      check(nmiRequest, 1'b1);
      faultIntEnable = 1'b0;
      faultClear = 3'h7;
      tick(1);
      faultClear = 3'h0;
      tick(1);
      check(faultFlags, 3'h0);
    end
    $display("select and fault tests done");
    serial = 4'h8;
    for (int m = 3; m < 6; m++) begin
      powerMode = fdcs_pkg::fdcs_mode_e'(m);
      tick(2);
      check(serialClockRequest, m < 4);
    end
    // Unit held in soft reset keeps its clock request
    serial = 4'hC;
    tick(2);
    check(serialClockRequest, 1'b1);
    serial = 4'h8;
    tick(2);
    check(serialClockRequest, 1'b0);
    cryOneBypassIn = 1'b1;
    tick(3);
    check({cryOneBypassActive, lowCurrentMode}, 2'h2);
    cryOneBypassIn = 1'b0;
    tick(1);
    check(cryOneBypassActive, 1'b0);
    tick(1);
    check(lowCurrentMode, 1'b1);
    cryTwoBypassIn = 1'b1;
    tick(1);
    check(lowCurrentMode, 1'b0);
    cryTwoBypassIn = 1'b0;
    powerMode = fdcs_pkg::FDCS_ACTIVE;
    tick(2);
    check(serialClockRequest, 1'b1);
    $display("sleep gating tests done");
    // Target above the 15 rises measured, so the loop speeds up
    targetCount = 16'h0064;
    loopEnable = 1'b1;
    tick(40);
    check({oscTapSelect, modulationCount}, 16'h01E0);
    tick(40);
    check({oscTapSelect, modulationCount > 5'h00}, 16'h001F);
    // Relock allowance past tap 15: 32 by 32 reference periods of 16 cycles
    tick(32 * 32 * 16);
    check(oscTapSelect > 5'h0F, 1'b1);
    clockGenOff = 1'b1;
    powerMode = fdcs_pkg::FDCS_SLEEP1;
    tick(2);
    hold = {oscTapSelect, modulationCount};
    tick(100);
    check({loopActive, oscTapSelect, modulationCount}, hold);
    intEntry = 1'b1;
    tick(2);
    check(loopActive, 1'b1);
    intEntry = 1'b0;
    clockGenOff = 1'b0;
    powerMode = fdcs_pkg::FDCS_SLEEP0;
    tick(2);
    check(loopActive, 1'b0);
    powerMode = fdcs_pkg::FDCS_ACTIVE;
    write_sel({fdcs_pkg::SRC_CRYSTAL2, fdcs_pkg::SRC_CRYSTAL2,
      fdcs_pkg::SRC_OSC});
    // Stay active three reference periods so the reopened loop starts a capture window
    tick(3 * 16);
    powerMode = fdcs_pkg::FDCS_SLEEP0;
    tick(3);
    check(loopActive, 1'b1);
    targetCount = 16'h0000;
    hold = {oscTapSelect, modulationCount};
    tick(200);
    check({oscTapSelect, modulationCount} < hold, 1'b1);
    $display("loop tests done");
    final_report();
  end
endmodule : fdcs_clock_system_test
bind fdcs_clock_system fdcs_clock_system_properties u_props (.mclk, .rst_n,
  .refClk, .powerMode, .clockGenOff, .intEntry, .selIn, .selWrite,
  .faultClear, .faultIntEnable, .cryOneBypassIn, .cryTwoBypassIn, .serial,
  .oscTapSelect, .modulationCount, .selOut, .faultFlags, .nmiRequest,
  .loopActive, .cryOneBypassActive, .lowCurrentMode, .serialClockRequest);

// ### fdcs_pkg.sv
// Package of constants and carrier types for the locked-loop clock system
package fdcs_pkg;
  // Tap select and modulation widths
  localparam int TAP_W = 5;
  localparam int MOD_W = 5;
  localparam logic [4:0] MOD_MAX = 5'h1F;
  localparam logic [4:0] TAP_MAX = 5'h1F;
  localparam logic [4:0] TAP_RESET = 5'h0_0F;
  localparam logic [4:0] MOD_RESET = 5'h0_00;
  // Reference periods per correction: capture then adjust
  localparam int CAPTURE_PERIODS = 2;
  localparam int ADJUST_PERIODS = 1;
  localparam int CORRECTION_PERIODS = CAPTURE_PERIODS + ADJUST_PERIODS;
  // Oscillator edge count width inside one capture window
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  // Clock source select codes
  localparam logic [2:0] SRC_OSC = 3'h0;
  localparam logic [2:0] SRC_CRYSTAL1 = 3'h1;
  localparam logic [2:0] SRC_CRYSTAL2 = 3'h2;
  // Power modes, sleep 0 lightest up to sleep 4 deepest
  typedef enum logic [2:0] {
    FDCS_ACTIVE = 3'b000,
    FDCS_SLEEP0 = 3'b001,
    FDCS_SLEEP1 = 3'b010,
    FDCS_SLEEP2 = 3'b011,
    FDCS_SLEEP3 = 3'b100,
    FDCS_SLEEP4 = 3'b101
  } fdcs_mode_e;
  // Loop phase
  typedef enum logic [1:0] {
    FDCS_IDLE = 2'b00,
    FDCS_CAPTURE = 2'b01,
    FDCS_ADJUST = 2'b10
  } fdcs_phase_e;
  // Clock source selections written by software
  typedef struct packed {
    logic [2:0] mainSel;
    logic [2:0] subMainSel;
    logic [2:0] auxSel;
  } fdcs_select_s;
  // Serial unit clock-request inputs
  typedef struct packed {
    logic asyncMode;
    logic softReset;
    logic txBusy;
    logic rxBusy;
  } fdcs_serial_s;
endpackage : fdcs_pkg
